// ==== core/ufc_channel.sv ====
// enhanced-feature control, flow control and reset states of one channel
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`include "ufc_map.svh"
module ufc_channel
  import ufc_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_por_n,
  input  wire logic [4:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_rx_valid,
  input  wire logic [7:0] i_rx_data,
  output logic            o_rxf_valid,
  output logic      [7:0] o_rxf_data,
  input  wire logic [6:0] i_rx_level,
  input  wire logic [6:0] i_tx_level,
  input  wire logic       i_tx_idle,
  input  wire logic       i_tx_line,
  output logic            o_tx,
  output logic            o_tx_go,
  output logic            o_flow_valid,
  output logic      [7:0] o_flow_data,
  input  wire logic       i_flow_ready,
  input  wire logic       i_cts_n,
  input  wire logic       i_dsr_n,
  input  wire logic       i_ri_n,
  input  wire logic       i_cd_n,
  output logic            o_rts_n,
  output logic            o_dtr_n,
  output logic            o_irq_n,
  output logic     [19:0] o_divisor,
  output logic      [7:0] o_line_ctrl,
  output logic      [7:0] o_fifo_ctrl
);

  ufc_state_type s_q;
  ufc_state_type s_d;
  ufc_state_type s_rst;
  logic [3:0]    modem;
  logic          enh;
  logic          soft_rst;
  logic          irq;
  logic [1:0]    rx_sel;
  logic [1:0]    tx_sel;
  logic [6:0]    halt_lvl;
  logic [6:0]    resume_lvl;
  logic [6:0]    trig_lvl;
  logic [7:0]    rd_val;
  logic          store;
  logic          off_hit;
  logic          on_hit;
  logic          spec;
  ufc_ev_type    ev_new;

  ufc_sync #(
    .width(4)
  ) u_modem_sync (
    .i_ref_clk(i_ref_clk),
    .i_resetn (i_por_n),
    .i_async  ({i_cd_n, i_ri_n, i_dsr_n, i_cts_n}),
    .o_sync   (modem)
  );

  function automatic logic [7:0] prot_wr(input logic [7:0] old_v, input logic [7:0] new_v,
                                         input logic [7:0] mask, input logic en);
    prot_wr = en ? new_v : ((old_v & mask) | (new_v & ~mask));
  endfunction

  assign enh        = s_q.enhanced_feature_control[`UFC_EFR_ENH];
  assign soft_rst   = !i_resetn || s_q.swrst;
  assign irq        = |(s_q.ev & s_q.evmask);
  assign rx_sel     = s_q.enhanced_feature_control[`UFC_EFR_RXSEL];
  assign tx_sel     = s_q.enhanced_feature_control[`UFC_EFR_TXSEL];
  assign halt_lvl   = {1'b0, s_q.flow_level_reg[`UFC_TCR_HALT], 2'b00};
  assign resume_lvl = {1'b0, s_q.flow_level_reg[`UFC_TCR_RESUME], 2'b00};
  assign trig_lvl   = (s_q.trigger_level_reg[`UFC_TLR_RXTRIG] != 4'h0) ?
                      {1'b0, s_q.trigger_level_reg[`UFC_TLR_RXTRIG], 2'b00} : `UFC_TRIG_MIN;

  always_comb begin
    s_d     = s_q;
    rd_val  = 8'h00;
    store   = 1'b1;
    off_hit = 1'b0;
    on_hit  = 1'b0;
    spec    = 1'b0;
    ev_new  = '0;
    s_d.rdata      = 8'h00;
    s_d.rxf_valid  = 1'b0;
    s_d.tx         = i_tx_line;
    s_d.tx_space_count      = {1'b0, i_tx_level};
    s_d.line_status_reg        = 8'h00;
    s_d.line_status_reg[`UFC_LSR_TEMT] = i_tx_idle;
    s_d.line_status_reg[`UFC_LSR_THRE] = (i_tx_level == `UFC_TX_DEPTH);
    s_d.line_status_reg[`UFC_LSR_DR]   = (i_rx_level != 7'h00);
    s_d.modem_prev = modem;

    // register read
    case (i_addr)
      `UFC_A_LCR:   rd_val = s_q.line_control_reg;
      `UFC_A_IER:   rd_val = s_q.interrupt_enable_reg;
      `UFC_A_ISR:   rd_val = {s_q.interrupt_status_reg[7:1], ~irq};
      `UFC_A_FCR:   rd_val = s_q.fifo_control_reg;
      `UFC_A_MCR:   rd_val = s_q.modem_control_reg;
      `UFC_A_LSR:   rd_val = s_q.line_status_reg;
      `UFC_A_MSR:   rd_val = {~modem, s_q.msr_delta};
      `UFC_A_SPR:   rd_val = s_q.scratch_reg;
      `UFC_A_TCR:   rd_val = s_q.flow_level_reg;
      `UFC_A_TLR:   rd_val = s_q.trigger_level_reg;
      `UFC_A_TX_SPACE_COUNT: rd_val = s_q.tx_space_count;
      `UFC_A_DLL:   rd_val = s_q.dll;
      `UFC_A_DLM:   rd_val = s_q.divisor_high_reg;
      `UFC_A_DLD:   rd_val = s_q.divisor_fraction_reg;
      `UFC_A_EFR:   rd_val = s_q.enhanced_feature_control;
      `UFC_A_FLOW_ON_CHAR_ONE:  rd_val = s_q.flow_on_char_one;
      `UFC_A_FLOW_ON_CHAR_TWO:  rd_val = s_q.flow_on_char_two;
      `UFC_A_FLOW_OFF_CHAR_ONE: rd_val = s_q.flow_off_char_one;
      `UFC_A_FLOW_OFF_CHAR_TWO: rd_val = s_q.flow_off_char_two;
      `UFC_A_EVST:  rd_val = {3'h0, s_q.ev};
      `UFC_A_EVMSK: rd_val = {3'h0, s_q.evmask};
      default:      rd_val = 8'h00;
    endcase
    if (i_rd) begin
      s_d.rdata = rd_val;
    end

    // register write, protected bits gated by the enhanced-write bit
    if (i_wr) begin
      case (i_addr)
        `UFC_A_LCR:   s_d.line_control_reg = i_wdata;
        `UFC_A_IER:   s_d.interrupt_enable_reg = prot_wr(s_q.interrupt_enable_reg, i_wdata, `UFC_PROT_IER, enh);
        `UFC_A_ISR:   s_d.interrupt_status_reg = enh ? ((s_q.interrupt_status_reg & ~`UFC_PROT_ISR) | (i_wdata & `UFC_PROT_ISR))
                                    : s_q.interrupt_status_reg;
        `UFC_A_FCR:   s_d.fifo_control_reg = prot_wr(s_q.fifo_control_reg, i_wdata, `UFC_PROT_FCR, enh);
        `UFC_A_MCR:   s_d.modem_control_reg = prot_wr(s_q.modem_control_reg, i_wdata, `UFC_PROT_MCR, enh);
        `UFC_A_SPR:   s_d.scratch_reg = i_wdata;
        `UFC_A_TCR:   s_d.flow_level_reg = prot_wr(s_q.flow_level_reg, i_wdata, `UFC_PROT_ALL, enh);
        `UFC_A_TLR:   s_d.trigger_level_reg = prot_wr(s_q.trigger_level_reg, i_wdata, `UFC_PROT_ALL, enh);
        `UFC_A_DLL:   s_d.dll = i_wdata;
        `UFC_A_DLM:   s_d.divisor_high_reg = i_wdata;
        `UFC_A_DLD:   s_d.divisor_fraction_reg = prot_wr(s_q.divisor_fraction_reg, i_wdata, `UFC_PROT_ALL, enh);
        `UFC_A_EFR:   s_d.enhanced_feature_control = i_wdata;
        `UFC_A_FLOW_ON_CHAR_ONE:  s_d.flow_on_char_one = i_wdata;
        `UFC_A_FLOW_ON_CHAR_TWO:  s_d.flow_on_char_two = i_wdata;
        `UFC_A_FLOW_OFF_CHAR_ONE: s_d.flow_off_char_one = i_wdata;
        `UFC_A_FLOW_OFF_CHAR_TWO: s_d.flow_off_char_two = i_wdata;
        `UFC_A_IOC:   s_d.swrst = i_wdata[`UFC_IOC_SWRST];
        `UFC_A_EVMSK: s_d.evmask = i_wdata[4:0];
        default:      s_d.swrst = s_q.swrst;
      endcase
    end

    // receive comparison
    if (i_rx_valid) begin
      s_d.armed_on  = 1'b0;
      s_d.armed_off = 1'b0;
      case (rx_sel)
        `UFC_SEL_ONE: begin
          off_hit = (i_rx_data == s_q.flow_off_char_one);
          on_hit  = (i_rx_data == s_q.flow_on_char_one);
        end
        `UFC_SEL_TWO: begin
          off_hit = (i_rx_data == s_q.flow_off_char_two);
          on_hit  = (i_rx_data == s_q.flow_on_char_two);
        end
        `UFC_SEL_BOTH: begin
          off_hit       = s_q.armed_off && (i_rx_data == s_q.flow_off_char_two);
          on_hit        = s_q.armed_on && (i_rx_data == s_q.flow_on_char_two);
          s_d.armed_off = (i_rx_data == s_q.flow_off_char_one);
          s_d.armed_on  = (i_rx_data == s_q.flow_on_char_one);
        end
        default: begin
          off_hit = 1'b0;
          on_hit  = 1'b0;
        end
      endcase
      store = !(off_hit || on_hit);
      spec  = s_q.enhanced_feature_control[`UFC_EFR_SPEC] && (i_rx_data == s_q.flow_off_char_two);
      if (spec && (rx_sel != `UFC_SEL_TWO)) begin
        store = 1'b1;
      end
      s_d.rxf_valid = store;
      s_d.rxf_data  = i_rx_data;
    end
    if (off_hit) begin
      s_d.local_halt = 1'b1;
    end else if (on_hit || (rx_sel == `UFC_SEL_OFF)) begin
      s_d.local_halt = 1'b0;
    end

    // events: set wins over the clearing read
    ev_new[`UFC_EV_SPEC]  = spec && s_q.interrupt_enable_reg[`UFC_IER_SPEC];
    ev_new[`UFC_EV_OFF]   = off_hit;
    ev_new[`UFC_EV_ON]    = on_hit;
    s_d.trig_seen         = (i_rx_level >= trig_lvl);
    ev_new[`UFC_EV_TRIG]  = s_d.trig_seen && !s_q.trig_seen;
    ev_new[`UFC_EV_MODEM] = |(modem ^ s_q.modem_prev);
    s_d.ev = ((i_rd && (i_addr == `UFC_A_EVST)) ? '0 : s_q.ev) | ev_new;
    s_d.msr_delta = ((i_rd && (i_addr == `UFC_A_MSR)) ? 4'h0 : s_q.msr_delta)
                    | (modem ^ s_q.modem_prev);
    if (i_rd && (i_addr == `UFC_A_ISR)) begin
      s_d.interrupt_status_reg[`UFC_ISR_SPEC] = 1'b0;
    end
    if (spec) begin
      s_d.interrupt_status_reg[`UFC_ISR_SPEC] = 1'b1;
    end

    // automatic request-to-send level tracking
    if (i_rx_level >= halt_lvl) begin
      s_d.rts_auto = 1'b1;
    end else if (i_rx_level < resume_lvl) begin
      s_d.rts_auto = 1'b0;
    end

    // transmit flow characters
    case (s_q.fsm)
      ufc_st_idle: begin
        if (tx_sel != `UFC_SEL_OFF) begin
          if (!s_q.remote_halt && (i_rx_level >= halt_lvl)) begin
            s_d.fsm       = ufc_st_first;
            s_d.send_on   = 1'b0;
            s_d.flow_data = (tx_sel == `UFC_SEL_TWO) ? s_q.flow_off_char_two : s_q.flow_off_char_one;
          end else if (s_q.remote_halt && (i_rx_level < resume_lvl)) begin
            s_d.fsm       = ufc_st_first;
            s_d.send_on   = 1'b1;
            s_d.flow_data = (tx_sel == `UFC_SEL_TWO) ? s_q.flow_on_char_two : s_q.flow_on_char_one;
          end
        end
      end
      ufc_st_first: begin
        if (i_flow_ready) begin
          if (tx_sel == `UFC_SEL_BOTH) begin
            s_d.fsm       = ufc_st_second;
            s_d.flow_data = s_q.send_on ? s_q.flow_on_char_two : s_q.flow_off_char_two;
          end else begin
            s_d.fsm         = ufc_st_idle;
            s_d.remote_halt = !s_q.send_on;
          end
        end
      end
      ufc_st_second: begin
        if (i_flow_ready) begin
          s_d.fsm         = ufc_st_idle;
          s_d.remote_halt = !s_q.send_on;
        end
      end
      default: s_d.fsm = ufc_st_idle;
    endcase

    // reset values; power-up alone reaches DLL, DLM, scratch and characters
    s_rst            = '0;
    s_rst.line_control_reg        = `UFC_RST_LCR;
    s_rst.interrupt_status_reg        = `UFC_RST_ISR;
    s_rst.line_status_reg        = `UFC_RST_LSR;
    s_rst.flow_level_reg        = `UFC_RST_TCR;
    s_rst.tx_space_count      = `UFC_RST_TX_SPACE_COUNT;
    s_rst.dll        = `UFC_RST_DLL;
    s_rst.divisor_high_reg        = `UFC_RST_DLM;
    s_rst.scratch_reg        = `UFC_RST_SPR;
    s_rst.flow_on_char_one       = `UFC_RST_CHAR;
    s_rst.flow_on_char_two       = `UFC_RST_CHAR;
    s_rst.flow_off_char_one      = `UFC_RST_CHAR;
    s_rst.flow_off_char_two      = `UFC_RST_CHAR;
    s_rst.tx         = 1'b1;
    s_rst.modem_prev = modem;
    s_rst.fsm        = ufc_st_idle;
    if (!i_por_n) begin
      s_d = s_rst;
    end else if (soft_rst) begin
      s_d       = s_rst;
      s_d.dll   = s_q.dll;
      s_d.divisor_high_reg   = s_q.divisor_high_reg;
      s_d.scratch_reg   = s_q.scratch_reg;
      s_d.flow_on_char_one  = s_q.flow_on_char_one;
      s_d.flow_on_char_two  = s_q.flow_on_char_two;
      s_d.flow_off_char_one = s_q.flow_off_char_one;
      s_d.flow_off_char_two = s_q.flow_off_char_two;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    s_q <= s_d;
  end

  assign o_rdata      = s_q.rdata;
  assign o_rxf_valid  = s_q.rxf_valid;
  assign o_rxf_data   = s_q.rxf_data;
  assign o_tx         = s_q.tx;
  assign o_flow_valid = (s_q.fsm != ufc_st_idle);
  assign o_flow_data  = s_q.flow_data;
  assign o_tx_go      = !s_q.local_halt
                        && !(s_q.enhanced_feature_control[`UFC_EFR_ACTS] && modem[`UFC_MSR_CTS]);
  assign o_rts_n      = (s_q.enhanced_feature_control[`UFC_EFR_ARTS] && s_q.modem_control_reg[`UFC_MCR_RTS]) ? s_q.rts_auto
                        : ~s_q.modem_control_reg[`UFC_MCR_RTS];
  assign o_dtr_n      = ~s_q.modem_control_reg[`UFC_MCR_DTR];
  assign o_irq_n      = ~irq;
  assign o_divisor    = {s_q.divisor_high_reg, s_q.dll, s_q.divisor_fraction_reg[`UFC_DLD_FRAC]};
  assign o_line_ctrl  = s_q.line_control_reg;
  assign o_fifo_ctrl  = s_q.fifo_control_reg;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_por_n);

  property p_rts_gpio;
    !s_q.enhanced_feature_control[`UFC_EFR_ARTS] |-> (o_rts_n == !s_q.modem_control_reg[`UFC_MCR_RTS]);
  endproperty
  a_rts_gpio: assert property (p_rts_gpio) else $error("rts not plain output");

  property p_cts_stop;
    (s_q.enhanced_feature_control[`UFC_EFR_ACTS] && modem[`UFC_MSR_CTS]) |-> !o_tx_go;
  endproperty
  a_cts_stop: assert property (p_cts_stop) else $error("tx allowed with cts high");

  property p_prot_keep;
    (i_wr && (i_addr == `UFC_A_TCR) && !enh && !soft_rst) |=> $stable(s_q.flow_level_reg);
  endproperty
  a_prot_keep: assert property (p_prot_keep) else $error("protected reg written");

  property p_reset_clear;
    !i_resetn |=> (s_q.interrupt_enable_reg == 8'h00) && (s_q.divisor_fraction_reg == 8'h00) && ((s_q.modem_control_reg & `UFC_PROT_MCR) == 8'h00);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("enhanced bits not cleared");

  property p_por_keep;
    !i_resetn |=> (s_q.scratch_reg == $past(s_q.scratch_reg)) && (s_q.flow_off_char_two == $past(s_q.flow_off_char_two));
  endproperty
  a_por_keep: assert property (p_por_keep) else $error("persistent reg reset");

  property p_reset_outs;
    !i_resetn ##1 !i_resetn |-> o_tx && o_rts_n && o_dtr_n && o_irq_n && (s_q.msr_delta == 4'h0);
  endproperty
  a_reset_outs: assert property (p_reset_outs) else $error("outputs not idle");

  property p_reset_vals;
    !i_resetn |=> (s_q.line_control_reg == `UFC_RST_LCR) && (s_q.flow_level_reg == `UFC_RST_TCR)
                  && (s_q.tx_space_count == `UFC_RST_TX_SPACE_COUNT) && (s_q.line_status_reg == `UFC_RST_LSR);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

  property p_special;
    (i_rx_valid && s_q.enhanced_feature_control[`UFC_EFR_SPEC] && (i_rx_data == s_q.flow_off_char_two)
     && (rx_sel != `UFC_SEL_TWO) && !soft_rst) |=> o_rxf_valid && s_q.interrupt_status_reg[`UFC_ISR_SPEC];
  endproperty
  a_special: assert property (p_special) else $error("special char not stored");

  property p_flow_off_char_two_drop;
    (i_rx_valid && s_q.enhanced_feature_control[`UFC_EFR_SPEC] && (rx_sel == `UFC_SEL_TWO)
     && (i_rx_data == s_q.flow_off_char_two) && !soft_rst) |=> !o_rxf_valid && s_q.ev[`UFC_EV_OFF];
  endproperty
  a_flow_off_char_two_drop: assert property (p_flow_off_char_two_drop) else $error("second off char stored");

  property p_pair_seq;
    (s_q.fsm == ufc_st_first && tx_sel == `UFC_SEL_BOTH && i_flow_ready && !soft_rst)
    |=> (s_q.fsm == ufc_st_second) && o_flow_valid;
  endproperty
  a_pair_seq: assert property (p_pair_seq) else $error("second char not sent");

endmodule

// ==== core/ufc_map.svh ====
// register offsets, field positions and reset values of the channel
`ifndef UFC_MAP_SVH
`define UFC_MAP_SVH

`define UFC_A_LCR      5'h00
`define UFC_A_IER      5'h01
`define UFC_A_ISR      5'h02
`define UFC_A_FCR      5'h03
`define UFC_A_MCR      5'h04
`define UFC_A_LSR      5'h05
`define UFC_A_MSR      5'h06
`define UFC_A_SPR      5'h07
`define UFC_A_TCR      5'h08
`define UFC_A_TLR      5'h09
`define UFC_A_TX_SPACE_COUNT    5'h0a
`define UFC_A_DLL      5'h0b
`define UFC_A_DLM      5'h0c
`define UFC_A_DLD      5'h0d
`define UFC_A_EFR      5'h0e
`define UFC_A_FLOW_ON_CHAR_ONE     5'h0f
`define UFC_A_FLOW_ON_CHAR_TWO     5'h10
`define UFC_A_FLOW_OFF_CHAR_ONE    5'h11
`define UFC_A_FLOW_OFF_CHAR_TWO    5'h12
`define UFC_A_IOC      5'h13
`define UFC_A_EVST     5'h14
`define UFC_A_EVMSK    5'h15

`define UFC_RST_LCR    8'h1d
`define UFC_RST_ISR    8'h01
`define UFC_RST_LSR    8'h60
`define UFC_RST_TCR    8'h0f
`define UFC_RST_TX_SPACE_COUNT  8'h40
`define UFC_RST_DLL    8'h01
`define UFC_RST_DLM    8'h00
`define UFC_RST_SPR    8'hff
`define UFC_RST_CHAR   8'h00

`define UFC_PROT_IER   8'hf0
`define UFC_PROT_ISR   8'h30
`define UFC_PROT_FCR   8'h30
`define UFC_PROT_MCR   8'he0
`define UFC_PROT_ALL   8'hff

`define UFC_EFR_RXSEL  1:0
`define UFC_EFR_TXSEL  3:2
`define UFC_EFR_ENH    4
`define UFC_EFR_SPEC   5
`define UFC_EFR_ARTS   6
`define UFC_EFR_ACTS   7
`define UFC_SEL_OFF    2'h0
`define UFC_SEL_TWO    2'h1
`define UFC_SEL_ONE    2'h2
`define UFC_SEL_BOTH   2'h3

`define UFC_TCR_HALT   3:0
`define UFC_TCR_RESUME 7:4
`define UFC_TLR_RXTRIG 7:4
`define UFC_TRIG_MIN   7'h01
`define UFC_TX_DEPTH   7'h40
`define UFC_DLD_FRAC   3:0

`define UFC_MCR_DTR    0
`define UFC_MCR_RTS    1
`define UFC_IER_SPEC   5
`define UFC_ISR_SPEC   4
`define UFC_ISR_NOIRQ  0
`define UFC_IOC_SWRST  3
`define UFC_LSR_DR     0
`define UFC_LSR_THRE   5
`define UFC_LSR_TEMT   6
`define UFC_MSR_CTS    0

`define UFC_EV_SPEC    0
`define UFC_EV_OFF     1
`define UFC_EV_ON      2
`define UFC_EV_TRIG    3
`define UFC_EV_MODEM   4

`endif

// ==== core/ufc_pkg.sv ====
// types shared by the channel logic
package ufc_pkg;

  typedef logic [7:0] ufc_byte_type;
  typedef logic [4:0] ufc_ev_type;

  typedef enum logic [2:0] {
    ufc_st_idle   = 3'b001,
    ufc_st_first  = 3'b010,
    ufc_st_second = 3'b100
  } ufc_flow_st_type;

  typedef struct packed {
    ufc_byte_type    line_control_reg;
    ufc_byte_type    interrupt_enable_reg;
    ufc_byte_type    interrupt_status_reg;
    ufc_byte_type    fifo_control_reg;
    ufc_byte_type    modem_control_reg;
    ufc_byte_type    line_status_reg;
    ufc_byte_type    scratch_reg;
    ufc_byte_type    flow_level_reg;
    ufc_byte_type    trigger_level_reg;
    ufc_byte_type    tx_space_count;
    ufc_byte_type    dll;
    ufc_byte_type    divisor_high_reg;
    ufc_byte_type    divisor_fraction_reg;
    ufc_byte_type    enhanced_feature_control;
    ufc_byte_type    flow_on_char_one;
    ufc_byte_type    flow_on_char_two;
    ufc_byte_type    flow_off_char_one;
    ufc_byte_type    flow_off_char_two;
    ufc_byte_type    rdata;
    ufc_byte_type    flow_data;
    ufc_byte_type    rxf_data;
    ufc_ev_type      ev;
    ufc_ev_type      evmask;
    logic [3:0]      msr_delta;
    logic [3:0]      modem_prev;
    logic            swrst;
    logic            tx;
    logic            local_halt;
    logic            remote_halt;
    logic            send_on;
    logic            armed_on;
    logic            armed_off;
    logic            rts_auto;
    logic            trig_seen;
    logic            rxf_valid;
    ufc_flow_st_type fsm;
  } ufc_state_type;

endpackage

// ==== core/ufc_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ufc_sync #(
  parameter int width = 4
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_resetn,
  input  wire logic [width-1:0] i_async,
  output logic      [width-1:0] o_sync
);
  typedef struct packed {
    logic [width-1:0] s1;
    logic [width-1:0] s2;
  } ufc_sync_state_type;

  ufc_sync_state_type s_q;
  ufc_sync_state_type s_d;

  always_comb begin
    s_d.s1 = i_async;
    s_d.s2 = s_q.s1;
    if (!i_resetn) begin
      s_d.s1 = {width{1'b1}};
      s_d.s2 = {width{1'b1}};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    s_q <= s_d;
  end

  assign o_sync = s_q.s2;
endmodule

// ==== sim/ufc_remote.sv ====
// remote serial device model facing the channel
`timescale 1ns/1ps
module ufc_remote (
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_flow_valid,
  input  wire logic [7:0] i_flow_data,
  output logic            o_rx_valid,
  output logic      [7:0] o_rx_data,
  output logic            o_flow_ready,
  output logic            o_cts_n
);
  logic [7:0] got[$];
  int         dly = 2;
  int         cnt;
  initial begin
    o_rx_valid   = 1'b0;
    o_rx_data    = 8'h00;
    o_flow_ready = 1'b0;
    o_cts_n      = 1'b1;
  end
  // one received character, data line scrambled after
  task automatic send(input logic [7:0] b);
    @(posedge i_ref_clk);
    o_rx_valid <= 1'b1;
    o_rx_data  <= b;
    @(posedge i_ref_clk);
    o_rx_valid <= 1'b0;
    o_rx_data  <= ~b;
  endtask
  task automatic cts(input logic v);
    @(posedge i_ref_clk);
    o_cts_n <= v;
  endtask
  // flow characters taken at the edge with ready high, ready rising after dly+1 cycles of valid
  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_flow_ready <= 1'b0;
      cnt          <= 0;
    end else if (o_flow_ready && i_flow_valid) begin
      got.push_back(i_flow_data);
      o_flow_ready <= 1'b0;
      cnt          <= 0;
    end else if (i_flow_valid) begin
      if (cnt >= dly) o_flow_ready <= 1'b1;
      else cnt <= cnt + 1;
    end
  end
endmodule

// ==== sim/testbench.sv ====
// register-level testbench of the channel
`timescale 1ns/1ps
`include "ufc_map.svh"
module testbench;
  logic       clk, rstn, porn, wr_stb, rd_stb, rx_valid, flow_ready, cts_n;
  logic       rxf_valid, tx, tx_go, flow_valid, rts_n, dtr_n, irq_n;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, rx_data, rxf_data, flow_data;
  logic [6:0] rx_level, tx_level;
  logic       tx_idle, tx_line, dsr_n, ri_n, cd_n;
  logic [7:0] line_ctrl, fifo_ctrl;
  logic [19:0] divisor;
  logic [7:0] exq[$];
  int         error_cnt, n_checks, last;
  logic [7:0] rst_v [0:22] = '{8'h1d, 8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h00, 8'hff,
    8'h0f, 8'h00, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};
  logic [7:0] fl [0:3] = '{8'h13, 8'h93, 8'h11, 8'h91};
  logic [7:0] rx_efr [0:8] = '{8'h10, 8'h12, 8'h12, 8'h11, 8'h11, 8'h13, 8'h13, 8'h32, 8'h32};
  logic [7:0] rx_ch [0:8] = '{8'h13, 8'h13, 8'h93, 8'h93, 8'h13, 8'h13, 8'h93, 8'h93, 8'h13};
  logic [7:0] rx_st [0:8] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01, 8'h00, 8'h01, 8'h00};

  ufc_channel i_ufc_channel (
    .i_ref_clk(clk), .i_resetn(rstn), .i_por_n(porn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_stb), .i_rd(rd_stb), .o_rdata(rdata), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .o_rxf_valid(rxf_valid), .o_rxf_data(rxf_data), .i_rx_level(rx_level),
    .i_tx_level(tx_level), .i_tx_idle(tx_idle), .i_tx_line(tx_line), .o_tx(tx), .o_tx_go(tx_go),
    .o_flow_valid(flow_valid), .o_flow_data(flow_data), .i_flow_ready(flow_ready),
    .i_cts_n(cts_n), .i_dsr_n(dsr_n), .i_ri_n(ri_n), .i_cd_n(cd_n), .o_rts_n(rts_n),
    .o_dtr_n(dtr_n), .o_irq_n(irq_n), .o_divisor(divisor), .o_line_ctrl(line_ctrl),
    .o_fifo_ctrl(fifo_ctrl));

  ufc_remote i_ufc_remote (
    .i_ref_clk(clk), .i_resetn(rstn & porn), .i_flow_valid(flow_valid),
    .i_flow_data(flow_data), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_flow_ready(flow_ready), .o_cts_n(cts_n));

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic w(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 check(rdata & m, e, $sformatf("read %h", a));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #1000000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    rstn = 1'b0; porn = 1'b0; wr_stb = 1'b0; rd_stb = 1'b0; addr = 5'h00; wdata = 8'h00;
    rx_level = 7'h00; tx_level = 7'h40;
    tx_idle = 1'b1; tx_line = 1'b1; dsr_n = 1'b1; ri_n = 1'b1; cd_n = 1'b1;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    porn <= 1'b1;
    cyc(2);
    check({4'h0, tx, rts_n, dtr_n, irq_n}, 8'h0f, "idle pins");
    for (int a = 0; a < 23; a++) rchk(5'(a), 8'hff, rst_v[a]);
    check(divisor[11:4], 8'h01, "divisor low");
    check(fifo_ctrl, 8'h00, "fifo ctrl");
    @(posedge clk) tx_line <= 1'b0;
    cyc(2);
    check(8'(tx), 8'h00, "tx follows line");
    @(posedge clk) tx_line <= 1'b1;
    tx_idle <= 1'b0;
    rchk(`UFC_A_LSR, 8'hff, 8'h20);
    @(posedge clk) tx_idle <= 1'b1;
    dsr_n <= 1'b0;
    ri_n  <= 1'b0;
    cd_n  <= 1'b0;
    cyc(4);
    rchk(`UFC_A_MSR, 8'hff, 8'hee);
    @(posedge clk) dsr_n <= 1'b1;
    ri_n  <= 1'b1;
    cd_n  <= 1'b1;
    cyc(4);
    w(5'h1f, 8'haa);
    rchk(5'h1f, 8'hff, 8'h00);
    @(posedge clk) tx_level <= 7'h20;
    rchk(`UFC_A_TX_SPACE_COUNT, 8'hff, 8'h20);
    $display("reset values done");
    w(`UFC_A_IER, 8'hff);
    rchk(`UFC_A_IER, 8'hff, 8'h0f);
    w(`UFC_A_EFR, 8'h10);
    w(`UFC_A_IER, 8'hf5);
    w(`UFC_A_TCR, 8'h12);
    w(`UFC_A_EFR, 8'h00);
    w(`UFC_A_IER, 8'h00);
    w(`UFC_A_TCR, 8'h34);
    w(`UFC_A_MCR, 8'he2);
    rchk(`UFC_A_IER, 8'hff, 8'hf0);
    rchk(`UFC_A_TCR, 8'hff, 8'h12);
    rchk(`UFC_A_MCR, 8'hff, 8'h02);
    check(8'(rts_n), 8'h00, "rts manual");
    w(`UFC_A_SPR, 8'h5a);
    w(`UFC_A_FLOW_ON_CHAR_ONE, 8'h11);
    w(`UFC_A_LCR, 8'h03);
    #1 check(line_ctrl, 8'h03, "line ctrl out");
    @(posedge clk) rstn <= 1'b0;
    repeat (2) @(posedge clk) rstn <= 1'b1;
    cyc(2);
    check({5'h0, tx, rts_n, irq_n}, 8'h07, "pins after reset");
    rchk(`UFC_A_IER, 8'hff, 8'h00);
    rchk(`UFC_A_TCR, 8'hff, 8'h0f);
    rchk(`UFC_A_LCR, 8'hff, 8'h1d);
    rchk(`UFC_A_SPR, 8'hff, 8'h5a);
    rchk(`UFC_A_FLOW_ON_CHAR_ONE, 8'hff, 8'h11);
    w(`UFC_A_IER, 8'h0f);
    w(`UFC_A_IOC, 8'h08);
    rchk(`UFC_A_IER, 8'hff, 8'h00);
    rchk(`UFC_A_SPR, 8'hff, 8'h5a);
    $display("write gate and reset done");
    for (int i = 0; i < 4; i++) w(5'(`UFC_A_FLOW_ON_CHAR_ONE + i), fl[(i + 2) % 4]);
    w(`UFC_A_EFR, 8'h10);
    w(`UFC_A_TCR, 8'h12);
    for (int m = 1; m < 4; m++) begin
      i_ufc_remote.dly = m * 2 - 2;
      i_ufc_remote.got.delete();
      exq.delete();
      for (int k = 0; k < 4; k++) if (m[1 - k % 2]) exq.push_back(fl[k]);
      w(`UFC_A_EFR, 8'h10);
      w(`UFC_A_EFR, 8'h10 | 8'(m << 2));
      @(posedge clk) rx_level <= 7'd8;
      cyc(14);
      @(posedge clk) rx_level <= 7'd2;
      cyc(14);
      check(8'(i_ufc_remote.got.size()), 8'(exq.size()), "flow count");
      foreach (exq[i]) check(i_ufc_remote.got[i], exq[i], "flow char");
    end
    $display("transmit flow done");
    w(`UFC_A_EFR, 8'h10);
    w(`UFC_A_EFR, 8'h50);
    w(`UFC_A_MCR, 8'h02);
    @(posedge clk) rx_level <= 7'd0;
    rchk(`UFC_A_EVST, 8'h00, 8'h00);
    @(posedge clk) rx_level <= 7'd8;
    cyc(3);
    check(8'(rts_n), 8'h01, "rts halt");
    rchk(`UFC_A_EVST, 8'h08, 8'h08);
    @(posedge clk) rx_level <= 7'd6;
    cyc(3);
    check(8'(rts_n), 8'h01, "rts between levels");
    @(posedge clk) rx_level <= 7'd3;
    cyc(3);
    check(8'(rts_n), 8'h00, "rts resume");
    w(`UFC_A_EFR, 8'h10);
    @(posedge clk) rx_level <= 7'd8;
    cyc(3);
    check(8'(rts_n), 8'h00, "rts plain output");
    @(posedge clk) rx_level <= 7'd0;
    w(`UFC_A_EFR, 8'h90);
    i_ufc_remote.cts(1'b0);
    cyc(5);
    check(8'(tx_go), 8'h01, "cts low");
    i_ufc_remote.cts(1'b1);
    cyc(5);
    check(8'(tx_go), 8'h00, "cts high");
    i_ufc_remote.cts(1'b0);
    cyc(5);
    check(8'(tx_go), 8'h01, "cts back low");
    $display("hardware flow done");
    w(`UFC_A_EFR, 8'h10);
    w(`UFC_A_IER, 8'h20);
    w(`UFC_A_EFR, 8'h30);
    rchk(`UFC_A_EVST, 8'h00, 8'h00);
    i_ufc_remote.send(8'h93);
    #1 check(8'(rxf_valid), 8'h01, "special stored");
    check(rxf_data, 8'h93, "special data");
    rchk(`UFC_A_ISR, 8'h10, 8'h10);
    check(8'(irq_n), 8'h01, "masked irq");
    w(`UFC_A_EFR, 8'h10);
    w(`UFC_A_EVMSK, 8'h02);
    w(`UFC_A_EFR, 8'h31);
    i_ufc_remote.send(8'h93);
    #1 check(8'(rxf_valid), 8'h00, "special dropped");
    cyc(1);
    check(8'(irq_n), 8'h00, "irq raised");
    rchk(`UFC_A_EVST, 8'h03, 8'h03);
    cyc(1);
    check(8'(irq_n), 8'h01, "irq cleared");
    last = -1;
    for (int i = 0; i < 9; i++) begin
      if (int'(rx_efr[i]) != last) begin
        w(`UFC_A_EFR, 8'h10);
        w(`UFC_A_EFR, rx_efr[i]);
      end
      last = int'(rx_efr[i]);
      i_ufc_remote.send(rx_ch[i]);
      #1 check(8'(rxf_valid), rx_st[i], "receive store");
    end
    $display("receive compare done");
    end_of_test();
  end
endmodule
